// ### inc/sbuf_pkg.sv
// constants and types shared by the serial buffer handshake block
// Behaviour
// - writing the transmit holding register clears the empty flag
// - moving holding data into the shift register sets the empty flag
// - holding register writes always accepted; an unmoved value is overwritten
// - at frame end, full flag still set means overrun error
// - reading the receive holding register clears the full flag
// - read racing a frame completion may return the new frame
// - transmit empty flag reads 1 after reset
// - full flag raises receive interrupt when mask bit 2 is set; every flag enabled in the mask raises irq
`default_nettype none
package sbuf_pkg;
    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_TXH = 8'h0c;
    localparam logic [7:0] ADDR_RXH = 8'h10;
    localparam logic [7:0] ADDR_IMASK = 8'h14;
    // ctrl fields
    localparam int CTRL_TX_ON = 5;
    localparam int CTRL_RX_ON = 4;
    localparam int CTRL_CKS_HI = 1;
    localparam int CTRL_CKS_LO = 0;
    // status fields
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_RX_FULL = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_TX_END = 2;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [3:0] IMASK_RST = 4'h0;
    // serial clock divide: bit period in pclk cycles (async mode)
    localparam int BIT_CYC = 16;
    localparam int FRAME_BITS = 8;
    typedef struct packed {
        logic sync_mode;
        logic tx_on;
        logic rx_on;
        logic cks_hi;
        logic cks_lo;
    } ctl_type;
endpackage
`default_nettype wire

// ### rtl/serial_buffer_flag_handshake.sv
// serial buffer handshake: holding registers, flags, pin control, apb
`default_nettype none
module serial_buffer_flag_handshake
    import sbuf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic irq,
    output logic receive_full_irq
);
    // ****************************************************
    // bus and control registers
    // ****************************************************
    ctl_type ctl_r;
    logic [7:0] thr_r, tsr_r, rhr_r, rsr_r;
    logic tx_empty_r, rx_full_r, overrun_r, tx_end_r;
    logic [3:0] imask_r;
    logic acc, wr, rd, hit;
    logic rx_s1, rx_s2, ck_s1, ck_s2, ck_d;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign hit = paddr inside {ADDR_MODE, ADDR_CTRL, ADDR_STAT, ADDR_TXH,
                               ADDR_RXH, ADDR_IMASK};
    // zero-wait slave; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
        end
    end
    logic wr_go, rd_go;
    assign wr_go = wr & pready;
    assign rd_go = rd & pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= '0;
            imask_r <= IMASK_RST;
        end else if (wr_go) begin
            if (paddr == ADDR_MODE)
                ctl_r.sync_mode <= pwdata[7];
            if (paddr == ADDR_CTRL) begin
                ctl_r.tx_on <= pwdata[CTRL_TX_ON];
                ctl_r.rx_on <= pwdata[CTRL_RX_ON];
                ctl_r.cks_hi <= pwdata[CTRL_CKS_HI];
                ctl_r.cks_lo <= pwdata[CTRL_CKS_LO];
            end
            if (paddr == ADDR_IMASK)
                imask_r <= pwdata[3:0];
        end
    end

    // ****************************************************
    // pin synchronisers and bit timing
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            ck_s1 <= 1'b1;
            ck_s2 <= 1'b1;
            ck_d <= 1'b1;
        end else begin
            rx_s1 <= rxd;
            rx_s2 <= rx_s1;
            ck_s1 <= sck_in;
            ck_s2 <= ck_s1;
            ck_d <= ck_s2;
        end
    end
    // external clock in sync mode when selects are 1x, else internal divider
    logic ext_ck, div_tick, bit_tick, ck_rise;
    logic [4:0] div_r;
    assign ext_ck = ctl_r.sync_mode & ctl_r.cks_hi;
    assign ck_rise = ck_s2 & ~ck_d;
    assign div_tick = (div_r == 5'(BIT_CYC - 1));
    assign bit_tick = ext_ck ? ck_rise : div_tick;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_r <= '0;
        else
            div_r <= div_tick ? 5'h00 : div_r + 5'h01;
    end

    // ****************************************************
    // transmitter
    // ****************************************************
    logic [3:0] tx_cnt_r;
    logic tx_busy_r, tx_load, tx_fin;
    assign tx_load = ctl_r.tx_on & ~tx_empty_r & ~tx_busy_r & bit_tick;
    assign tx_fin = ctl_r.tx_on & tx_busy_r & bit_tick
                    & (tx_cnt_r == 4'(FRAME_BITS));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_r <= 8'h00;
        end else if (wr_go && paddr == ADDR_TXH) begin
            thr_r <= pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_r <= 1'b1;
        end else if (wr_go && paddr == ADDR_TXH) begin
            tx_empty_r <= 1'b0;
        end else if (tx_load) begin
            tx_empty_r <= 1'b1;
        end
    end
    // async frame: start, 8 data lsb first, stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsr_r <= 8'h00;
            tx_cnt_r <= 4'h0;
            tx_busy_r <= 1'b0;
            txd <= 1'b1;
        end else if (!ctl_r.tx_on) begin
            tx_busy_r <= 1'b0;
            txd <= 1'b1;
        end else if (tx_load) begin
            tsr_r <= thr_r;
            tx_busy_r <= 1'b1;
            tx_cnt_r <= 4'h0;
            txd <= 1'b0;
        end else if (tx_busy_r && bit_tick) begin
            if (tx_cnt_r == 4'(FRAME_BITS)) begin
                tx_busy_r <= 1'b0;
                txd <= 1'b1;
            end else begin
                txd <= tsr_r[0];
                tsr_r <= {1'b1, tsr_r[7:1]};
                tx_cnt_r <= tx_cnt_r + 4'h1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_end_r <= 1'b0;
        else if (tx_fin && tx_empty_r)
            tx_end_r <= 1'b1;
        else if (wr_go && paddr == ADDR_STAT && pwdata[ST_TX_END])
            tx_end_r <= 1'b0;
    end

    // ****************************************************
    // receiver
    // ****************************************************
    logic [3:0] rx_cnt_r;
    logic rx_busy_r, rx_done, rd_rhr;
    assign rd_rhr = rd_go & (paddr == ADDR_RXH);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsr_r <= 8'h00;
            rx_cnt_r <= 4'h0;
            rx_busy_r <= 1'b0;
        end else if (!ctl_r.rx_on) begin
            rx_busy_r <= 1'b0;
        end else if (!rx_busy_r) begin
            if (bit_tick && !rx_s2) begin
                rx_busy_r <= 1'b1;
                rx_cnt_r <= 4'h0;
            end
        end else if (bit_tick) begin
            if (rx_cnt_r == 4'(FRAME_BITS)) begin
                rx_busy_r <= 1'b0;
            end else begin
                rsr_r <= {rx_s2, rsr_r[7:1]};
                rx_cnt_r <= rx_cnt_r + 4'h1;
            end
        end
    end
    assign rx_done = rx_busy_r & bit_tick & (rx_cnt_r == 4'(FRAME_BITS));
    // overrun when full still set at frame end; data is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rhr_r <= 8'h00;
            overrun_r <= 1'b0;
        end else begin
            if (rx_done && !rx_full_r)
                rhr_r <= rsr_r;
            if (rx_done && rx_full_r)
                overrun_r <= 1'b1;
            else if (wr_go && paddr == ADDR_STAT && pwdata[ST_OVERRUN])
                overrun_r <= 1'b0;
        end
    end
    // read clears full; a frame completing while full is clear wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rx_full_r <= 1'b0;
        else if (rx_done && !rx_full_r)
            rx_full_r <= 1'b1;
        else if (rd_rhr)
            rx_full_r <= 1'b0;
    end

    // ****************************************************
    // read data, pins, interrupts
    // ****************************************************
    logic [7:0] stat;
    logic [3:0] events;
    assign stat = {tx_empty_r, rx_full_r, overrun_r, 2'b00, tx_end_r, 2'b00};
    assign events = {tx_empty_r, rx_full_r, overrun_r, tx_end_r};
    // read racing a frame end sees the new frame when full was clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                ADDR_MODE: prdata <= {24'h0, ctl_r.sync_mode, 7'h00};
                ADDR_CTRL: prdata <= {26'h0, ctl_r.tx_on, ctl_r.rx_on,
                                      2'b00, ctl_r.cks_hi, ctl_r.cks_lo};
                ADDR_STAT: prdata <= {24'h0, stat};
                ADDR_TXH: prdata <= {24'h0, thr_r};
                ADDR_RXH: prdata <= {24'h0,
                    (rx_done && !rx_full_r) ? rsr_r : rhr_r};
                ADDR_IMASK: prdata <= {28'h0, imask_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
    // clock output driven in sync mode with selects 0x
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_oe <= 1'b0;
            sck_out <= 1'b1;
        end else begin
            sck_oe <= ctl_r.sync_mode & ~ctl_r.cks_hi;
            sck_out <= (ctl_r.tx_on | ctl_r.rx_on) ? div_r[3] : 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            receive_full_irq <= 1'b0;
        end else begin
            irq <= |(events & imask_r);
            receive_full_irq <= rx_full_r & imask_r[2];
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    sequence s_txh_write;
        wr_go && paddr == ADDR_TXH;
    endsequence
    chk_tx_empty_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_txh_write |=> !tx_empty_r)
        else $error("empty flag not cleared by write");
    chk_tx_empty_set: assert property (@(posedge pclk) disable iff (!presetn)
        tx_load && !(wr_go && paddr == ADDR_TXH)
        |=> tx_empty_r && tx_busy_r)
        else $error("empty flag not set on transfer");
    chk_tx_overwrite: assert property (@(posedge pclk) disable iff (!presetn)
        s_txh_write |=> thr_r == $past(pwdata[7:0]))
        else $error("holding register not overwritten");
    chk_overrun_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && rx_full_r |=> overrun_r && $stable(rhr_r))
        else $error("overrun not flagged");
    chk_rx_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_rhr && !rx_done |=> !rx_full_r)
        else $error("full flag not cleared by read");
    chk_rx_race: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr == ADDR_RXH && rx_done && !rx_full_r
        |=> prdata[7:0] == rhr_r)
        else $error("race read did not return new frame");
    chk_rx_irq: assert property (@(posedge pclk) disable iff (!presetn)
        rx_full_r && imask_r[2] |=> receive_full_irq && irq)
        else $error("receive interrupt missing");
    chk_pin_mux: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 sck_oe == $past(ctl_r.sync_mode & ~ctl_r.cks_hi))
        else $error("clock pin enable lags write");
endmodule
`default_nettype wire

// ### testbench/serial_station.sv
// remote serial station model: frame sender, frame receiver, link clock
`default_nettype none
module serial_station
    import sbuf_pkg::*;
(
    input wire logic pclk,
    input wire logic txd,
    output logic rxd,
    output logic sck_in,
    output logic [7:0] got,
    output logic got_v
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************
    // line side
    // ****************************************************
    logic busy = 1'b0;
    logic [7:0] sh;
    // link clock stands still between frames, odd phase to pclk
    initial begin
        sck_in = 1'b1;
        #3;
        forever #40 sck_in <= busy ? ~sck_in : 1'b1;
    end
    initial begin
        rxd = 1'b1;
        got = 8'h00;
        got_v = 1'b0;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        busy = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rxd <= f[i];
            repeat (BIT_CYC - 1) @(posedge pclk);
        end
        busy = 1'b0;
    endtask
    // clock-synchronous frame: data changes on the falling link clock
    task automatic send_sync(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        busy = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(negedge sck_in);
            rxd <= f[i];
        end
        @(posedge sck_in);
        busy = 1'b0;
    endtask
    // sample mid-bit, lsb first
    initial begin
        forever begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge pclk);
            for (int i = 0; i < FRAME_BITS; i++) begin
                repeat (BIT_CYC) @(posedge pclk);
                sh[i] = txd;
            end
            repeat (BIT_CYC) @(posedge pclk);
            got <= sh;
            got_v <= 1'b1;
            @(posedge pclk);
            got_v <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_serial_buffer_flag_handshake.sv
// self-checking bench for the serial buffer handshake block
`default_nettype none
module tb_serial_buffer_flag_handshake
    import sbuf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************
    // signals and helpers
    // ****************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, got;
    logic [31:0] pwdata, prdata;
    logic rxd, txd, sck_in, sck_out, sck_oe, irq, receive_full_irq, got_v;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 30;
    logic [64:0] rd_q[$];
    logic [7:0] tx_q[$];
    logic [7:0] b[5];
    localparam logic [16:0] PIN_SEQ[4] = '{{ADDR_MODE, 8'h80, 1'b1},
        {ADDR_CTRL, 8'h02, 1'b0}, {ADDR_MODE, 8'h00, 1'b0},
        {ADDR_CTRL, 8'h00, 1'b0}};
    serial_buffer_flag_handshake i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .irq(irq),
        .receive_full_irq(receive_full_irq));
    serial_station i_peer (.pclk(pclk), .txd(txd), .rxd(rxd),
        .sck_in(sck_in), .got(got), .got_v(got_v));
    // full-speed run only; sub-clock states are never entered
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // reads note the expected {err, mask, value}; a monitor compares
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) rd_q.push_back({e, m, d});
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_mismatch++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v,
        input logic [31:0] m);
        apb(1'b0, a, v, m, 1'b0);
    endtask
    // sel 0 irq, 1 receive irq, 2 all sent bytes seen
    task automatic wait_hi(input int sel);
        int k;
        for (k = 0; k < 2000; k++) begin
            @(posedge pclk);
            if (sel == 0 && irq === 1'b1) break;
            if (sel == 1 && receive_full_irq === 1'b1) break;
            if (sel == 2 && tx_q.size() == 0) break;
        end
        if (k == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    always @(posedge pclk) begin
        logic [64:0] e;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = rd_q.pop_front();
            check({pslverr, prdata & e[63:32]},
                  {e[64], e[31:0] & e[63:32]});
        end
        if (got_v === 1'b1)
            check({25'h0, got}, {25'h0, tx_q.pop_front()});
    end
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        for (int i = 0; i < 5; i++) b[i] = 8'($random(seed));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STAT, 32'h80, 32'hff);
        apb(1'b0, 8'h18, 32'h0, 32'hffffffff, 1'b1);
        wr(ADDR_CTRL, 32'h30);
        rd(ADDR_STAT, 32'h80, 32'h80);
        tx_q.push_back(b[0]);
        wr(ADDR_TXH, {24'h0, b[0]});
        wr(ADDR_TXH, {24'h0, b[1]});
        rd(ADDR_STAT, 32'h00, 32'h80);
        wr(ADDR_TXH, {24'h0, b[2]});
        tx_q.push_back(b[2]);
        wait_hi(2);
        rd(ADDR_STAT, 32'h80, 32'h80);
        wr(ADDR_IMASK, 32'h4);
        i_peer.send(b[3]);
        wait_hi(1);
        check({32'h0, irq}, 33'h1);
        wr(ADDR_IMASK, 32'h0);
        @(posedge pclk);
        @(negedge pclk);
        check({32'h0, receive_full_irq}, 33'h0);
        // single read before the next frame
        rd(ADDR_RXH, {24'h0, b[3]}, 32'hff);
        rd(ADDR_STAT, 32'h00, 32'h40);
        wr(ADDR_IMASK, 32'h2);
        i_peer.send(b[4]);
        i_peer.send(b[0]);
        wait_hi(0);
        rd(ADDR_STAT, 32'h60, 32'h60);
        rd(ADDR_RXH, {24'h0, b[4]}, 32'hff);
        wr(ADDR_STAT, 32'h20);
        rd(ADDR_STAT, 32'h00, 32'h60);
        // sync-mode frame timed by the external link clock
        wr(ADDR_MODE, 32'h80);
        wr(ADDR_CTRL, 32'h12);
        wr(ADDR_IMASK, 32'h4);
        i_peer.send_sync(b[1]);
        wait_hi(1);
        rd(ADDR_RXH, {24'h0, b[1]}, 32'hff);
        wr(ADDR_CTRL, 32'h30);
        wr(ADDR_MODE, 32'h00);
        for (int i = 0; i < 4; i++) begin
            wr(PIN_SEQ[i][16:9], {24'h0, PIN_SEQ[i][8:1]});
            @(posedge pclk);
            @(negedge pclk);
            check({32'h0, sck_oe}, {32'h0, PIN_SEQ[i][0]});
            if (i > 0) check({32'h0, sck_out}, 33'h1);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
